// >>> src/iec_edge_clear_pending.sv
/*
 * Interrupt edge-clear command and raw pending register behind an
 * AXI4-Lite slave, with an event status/mask pair and one interrupt.
 * The six external pins pass an edge bank; a write that fires sends
 * it a one-cycle clear and it returns the latched edges.
 * Assumes on-chip sources are synchronous to mclk, external pins are
 * not, and the level register block outside supplies source levels.
 * Assumes the master keeps at most one write and one read open.
 * Limitation: a pin pulse shorter than one clock may be missed.
 * Limitation: pending lags on-chip sources by a clock, delivery by two; pins take four and five.
 * Reserved selector codes are stored but clear nothing.
 */
// Local design decision: register access over AXI4-Lite.
// Function
// - Writing fire clears selected external edge
// - Fire bit self-clears, always reads zero
// - Four-bit selector, reset zero, reserved codes
// - Selector codes map to external inputs 0-5
// - Pending shows on-chip request or pin edge latch, ignores levels
// - Pending read-only, reset zero, writes ignored
// - Bit 31 serial, 30-27 second DMA
// - Bits 26-23 second PCI, codec, PCI power
// - Level zero source never delivered onward
`timescale 1ns/1ps
module iec_edge_clear_pending
   import iec_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [DATA_W-1:0]      s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   // AXI4-Lite read data
   output logic [DATA_W-1:0]           s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // On-chip request lines, same clock
   input  wire logic                   spi_req,
   input  wire logic [3:0]             second_dma_unit_req,
   input  wire logic                   second_pci_controller_req,
   input  wire logic                   audio_codec_power_event_req,
   input  wire logic                   audio_codec_link_req,
   input  wire logic                   pci_power_management_req,
   input  wire logic [OTHER_W-1:0]     other_req,
   // External interrupt pins, asynchronous
   input  wire logic [N_EXT-1:0]       ext_int_pin,
   // Programmed levels, three bits per source
   input  wire logic [N_SRC*LVL_W-1:0] source_priority_levels,
   // Requests passed on to priority resolution
   output logic [N_SRC-1:0]            source_request_vector,
   output logic                        irq
);

   // All state in one record: one comb copy, one register
   typedef struct packed {
      // Write channel capture
      logic              aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_got;
      logic [DATA_W-1:0] w_data;
      logic [3:0]        w_strb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;

      // Read channel
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;

      // Block state
      logic [SEL_W-1:0]  sel;
      logic [N_EXT-1:0]  clr;
      logic [N_SRC-1:0]  pend;
      logic [N_SRC-1:0]  deliver;
      logic [N_EXT-1:0]  status;
      logic [N_EXT-1:0]  mask;
      logic              irq;
   } iec_state_t;

   iec_state_t s_q;
   iec_state_t s_d;

   // Carrier to the edge bank, same clock at both ends
   iec_edge_if eif ();

   // Pins are asynchronous; only the bank touches them raw
   // External pins: sync, edge latch, clear
   iec_edge_bank u_bank (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .ext_int_pin (ext_int_pin),
      .eif         (eif)
   );

   // Clear pulse comes straight from a flip-flop
   assign eif.clr = s_q.clr;

   // Levels come from outside already clocked, so no sync here
   // level zero gates delivery
   logic [N_SRC-1:0] lvl_on;
   genvar gi;
   generate
      for (gi = 0; gi < N_SRC; gi++) begin : g_lvl
         assign lvl_on[gi] = (source_priority_levels[gi*LVL_W +: LVL_W] != LVL_OFF);
      end
   endgenerate

   // Next state: bus, command, pending, events
   always_comb begin
      logic [N_SRC-1:0] pend_v;
      logic [DATA_W-1:0] rd_v;
      logic [1:0]        rr_v;
      logic [SEL_W-1:0]  sel_v;
      logic [N_EXT-1:0]  w1c_v;
      pend_v = PEND_RESET;
      rd_v   = '0;
      rr_v   = RESP_OKAY;
      sel_v  = s_q.sel;
      w1c_v  = '0;
      s_d    = s_q;
      // Clear pulse lasts one cycle only
      s_d.clr = '0;

      // Take address and data in either order
      // Each half waits in the record until the other arrives
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_got  = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_got  = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      // Response stands until the master takes it
      if (s_axi_bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // Commit once both halves are held
      // Effects land on the clock that raises bvalid
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OKAY;
         // Word decode; address bits 1:0 are ignored
         unique case (s_q.aw_addr[ADDR_W-1:2])
            OFS_CLEAR_CMD[ADDR_W-1:2]: begin
               // Byte 0 holds the selector, byte 1 the fire bit
               // selector held, reset zero
               if (s_q.w_strb[0]) begin
                  sel_v = s_q.w_data[SEL_LSB +: SEL_W];
               end
               s_d.sel = sel_v;
               // fire issues one clear
               // Uses the selector written in the same word
               if (s_q.w_strb[1] && s_q.w_data[CLR_FIRE_BIT]) begin
                  s_d.clr = iec_sel_decode(sel_v);
               end
            end
            OFS_PENDING[ADDR_W-1:2]: begin
               s_d.bresp = RESP_OKAY;
            end
            OFS_IRQ_STATUS[ADDR_W-1:2]: begin
               if (s_q.w_strb[0]) begin
                  // Write one to clear; an edge in the same clock wins
                  w1c_v = s_q.w_data[N_EXT-1:0];
               end
            end
            OFS_IRQ_MASK[ADDR_W-1:2]: begin
               if (s_q.w_strb[0]) begin
                  // A one lets that event raise irq
                  s_d.mask = s_q.w_data[N_EXT-1:0];
               end
            end
            default: begin
               // Unmapped write: error answer, nothing changes
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // One write at a time: no capture while a response waits
      // Ready low while a half is held, so none is overwritten
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready  = !s_d.w_got && !s_d.bvalid;

      // Read mux from current state
      // Reads have no side effects, so the mux runs every cycle
      unique case (s_axi_araddr[ADDR_W-1:2])
         OFS_CLEAR_CMD[ADDR_W-1:2]: begin
            // Fire has no storage, so it can never read back
            // fire reads as zero
            rd_v[SEL_LSB +: SEL_W] = s_q.sel;
         end
         OFS_PENDING[ADDR_W-1:2]: begin
            // Whole pending word, reserved bit already zero
            rd_v = s_q.pend;
         end
         OFS_IRQ_STATUS[ADDR_W-1:2]: begin
            rd_v[N_EXT-1:0] = s_q.status;
         end
         OFS_IRQ_MASK[ADDR_W-1:2]: begin
            rd_v[N_EXT-1:0] = s_q.mask;
         end
         default: begin
            // Unmapped read: error answer, data left zero
            rr_v = RESP_SLVERR;
         end
      endcase

      // Read: answer one cycle after the address is taken
      // Data stays frozen while rvalid waits for rready
      if (s_axi_rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = rd_v;
         s_d.rresp  = rr_v;
      end
      s_d.arready = !s_d.rvalid;

      // Pending is registered so a read sees one clock's word
      // raw requests, no level or mask
      pend_v[OTHER_W-1:0] = other_req;
      pend_v[PEND_SPI]               = spi_req;
      pend_v[PEND_DMA2_LSB +: 4]     = second_dma_unit_req;
      pend_v[PEND_PCI2]              = second_pci_controller_req;
      pend_v[PEND_ACPME]             = audio_codec_power_event_req;
      pend_v[PEND_ACLINK]            = audio_codec_link_req;
      pend_v[PEND_PCIPM]             = pci_power_management_req;

      // External inputs report their latched edge
      // They stay set until software fires a clear
      pend_v[EXT_PEND_LSB +: N_EXT]  = eif.latch;
      // Written last so no source can reach it
      // reserved pending bit zero
      pend_v[PEND_RSVD]              = 1'b0;
      s_d.pend = pend_v;

      // One clock behind pending, ahead of priority logic
      // disabled sources withheld
      s_d.deliver = s_q.pend & lvl_on;

      // Edge events are sticky; a set in the clear cycle wins
      s_d.status = (s_q.status & ~w1c_v) | eif.rise;
      // Irq from next state, so it adds no clock of lag
      s_d.irq    = |(s_d.status & s_d.mask);
   end

   // Reset loads constants only; no logic in the reset branch
   // State register; every output is a field of it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q         <= '0;
         s_q.sel     <= SEL_RESET;
         s_q.pend    <= PEND_RESET;
         s_q.status  <= STATUS_RESET;
         s_q.mask    <= MASK_RESET;
         s_q.bresp   <= RESP_OKAY;
         s_q.rresp   <= RESP_OKAY;
      end else begin
         s_q <= s_d;
      end
   end

   // No output is combinational, which keeps bus timing clean
   // Port drive straight from the state register
   assign s_axi_awready         = s_q.awready;
   assign s_axi_wready          = s_q.wready;
   assign s_axi_bvalid          = s_q.bvalid;
   assign s_axi_bresp           = s_q.bresp;
   assign s_axi_arready         = s_q.arready;
   assign s_axi_rvalid          = s_q.rvalid;
   assign s_axi_rdata           = s_q.rdata;
   assign s_axi_rresp           = s_q.rresp;
   assign source_request_vector = s_q.deliver;
   assign irq                   = s_q.irq;

endmodule

// >>> src/iec_pkg.sv
/*
 * Shared constants for the edge-clear and pending block: register
 * offsets, field positions, reset values and the selector decode.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package iec_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned DATA_W       = 32;

   // Register byte offsets
   localparam logic [15:0] OFS_CLEAR_CMD  = 16'hF660;
   localparam logic [15:0] OFS_PENDING    = 16'hF680;
   localparam logic [15:0] OFS_IRQ_STATUS = 16'hF6A0;
   localparam logic [15:0] OFS_IRQ_MASK   = 16'hF6A4;

   // Clear command fields
   localparam int unsigned CLR_FIRE_BIT = 8;
   localparam int unsigned SEL_LSB      = 0;
   localparam int unsigned SEL_W        = 4;
   localparam logic [3:0]  SEL_RESET    = 4'h0;

   // External inputs and their pending positions
   localparam int unsigned N_EXT        = 6;
   localparam int unsigned EXT_PEND_LSB = 2;
   localparam int unsigned N_SRC        = 32;

   // Named pending positions
   localparam int unsigned PEND_SPI      = 31;
   localparam int unsigned PEND_DMA2_LSB = 27;
   localparam int unsigned PEND_PCI2     = 26;
   localparam int unsigned PEND_ACPME    = 25;
   localparam int unsigned PEND_ACLINK   = 24;
   localparam int unsigned PEND_PCIPM    = 23;
   localparam int unsigned PEND_RSVD     = 20;
   localparam int unsigned OTHER_W       = 23;
   localparam logic [31:0] PEND_RESET    = 32'h0000_0000;

   // Level coding: zero means the source is disabled
   localparam int unsigned LVL_W        = 3;
   localparam logic [2:0]  LVL_OFF      = 3'h0;

   // Event status and mask resets
   localparam logic [5:0]  STATUS_RESET = 6'h00;
   localparam logic [5:0]  MASK_RESET   = 6'h00;

   // Selector codes of the six external inputs
   localparam logic [3:0]  SEL_EXT0     = 4'h2;
   localparam logic [3:0]  SEL_EXT1     = 4'h3;
   localparam logic [3:0]  SEL_EXT2     = 4'h4;
   localparam logic [3:0]  SEL_EXT3     = 4'h5;
   localparam logic [3:0]  SEL_EXT4     = 4'h6;
   localparam logic [3:0]  SEL_EXT5     = 4'hB;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // Selector code to one-hot external input; other codes select none
   function automatic logic [5:0] iec_sel_decode(input logic [3:0] code);
      logic [5:0] hot;
      hot = 6'h00;
      unique case (code)
         SEL_EXT0: hot = 6'h01;
         SEL_EXT1: hot = 6'h02;
         SEL_EXT2: hot = 6'h04;
         SEL_EXT3: hot = 6'h08;
         SEL_EXT4: hot = 6'h10;
         SEL_EXT5: hot = 6'h20;
         default:  hot = 6'h00;
      endcase
      return hot;
   endfunction

endpackage

// >>> src/iec_edge_if.sv
/*
 * Carrier between the register core and the external edge bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface iec_edge_if;
   logic [5:0] clr;   // One-cycle clear per input
   logic [5:0] latch; // Latched edge per input
   logic [5:0] rise;  // One-cycle edge event per input

   modport bank (input clr, output latch, output rise);
   modport core (output clr, input latch, input rise);
endinterface

// >>> src/iec_edge_bank.sv
/*
 * Edge bank for the external interrupt pins: two-stage synchroniser,
 * rising-edge detector and a latch per pin that software clears.
 * Assumes asynchronous pins and a single clock mclk.
 */
`timescale 1ns/1ps
module iec_edge_bank
   import iec_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [N_EXT-1:0] ext_int_pin,
   iec_edge_if.bank              eif
);

   typedef struct packed {
      logic [N_EXT-1:0] meta;
      logic [N_EXT-1:0] sync;
      logic [N_EXT-1:0] prev;
      logic [N_EXT-1:0] latch;
      logic [N_EXT-1:0] rise;
   } iec_bank_t;

   iec_bank_t s_q;
   iec_bank_t s_d;

   // Edge detect and latch; meta feeds only the second stage
   always_comb begin
      s_d      = s_q;
      s_d.meta = ext_int_pin;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
      s_d.rise = s_q.sync & ~s_q.prev;
      // selected latch cleared
      // Set wins so an edge in the clear cycle survives
      s_d.latch = (s_q.latch & ~eif.clr) | s_d.rise;
   end

   // State register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign eif.latch = s_q.latch;
   assign eif.rise  = s_q.rise;

endmodule

// >>> bench/iec_chk.sv
/* Port checker for the edge-clear and pending block.
   Assumes one clock mclk and the async reset sys_rst. */
`timescale 1ns/1ps
module iec_chk
   import iec_pkg::*;
(
   input wire logic                   mclk,
   input wire logic                   sys_rst,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [ADDR_W-1:0]      s_axi_araddr,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [DATA_W-1:0]      s_axi_rdata,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire logic                   spi_req,
   input wire logic [N_SRC*LVL_W-1:0] source_priority_levels,
   input wire logic [N_SRC-1:0]       source_request_vector
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Read address taken this edge
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

   read_lat_a: assert property (ar_hs |=> s_axi_rvalid)
      else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   wr_lat_a: assert property (aw_hs |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   cmd_zero_a: assert property (ar_hs && s_axi_araddr == OFS_CLEAR_CMD |=> s_axi_rdata[31:4] == 28'h0)
      else $error("command reads nonzero");
   pend_rsvd_a: assert property (ar_hs && s_axi_araddr == OFS_PENDING |=> !s_axi_rdata[PEND_RSVD])
      else $error("reserved pending bit set");
   spi_pend_a: assert property (spi_req[*3] ##0 (ar_hs && s_axi_araddr == OFS_PENDING) |=> s_axi_rdata[31])
      else $error("serial request not pending");
   lvl_off_a: assert property ((source_priority_levels[95:93] == 3'h0)[*3] |-> !source_request_vector[31])
      else $error("disabled source delivered");

   cover property (ar_hs && s_axi_araddr == OFS_PENDING);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind iec_edge_clear_pending iec_chk iec_chk_inst (.mclk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .spi_req,
   .source_priority_levels, .source_request_vector);

// >>> bench/iec_src_model.sv
/* Model of the request sources and pins facing the block.
   Assumes the bench sets wanted vectors; drives them after each edge. */
`timescale 1ns/1ps
module iec_src_model
   import iec_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic [31:0]       req_set,
   input  wire logic [5:0]        pin_set,
   input  wire logic [95:0]       lvl_set,
   output logic                   spi_req,
   output logic [3:0]             second_dma_unit_req,
   output logic                   second_pci_controller_req,
   output logic                   audio_codec_power_event_req,
   output logic                   audio_codec_link_req,
   output logic                   pci_power_management_req,
   output logic [OTHER_W-1:0]     other_req,
   output logic [N_EXT-1:0]       ext_int_pin,
   output logic [N_SRC*LVL_W-1:0] source_priority_levels
);
   always @(posedge mclk) begin
      {spi_req, second_dma_unit_req, second_pci_controller_req, audio_codec_power_event_req,
         audio_codec_link_req, pci_power_management_req, other_req} <= req_set;
      ext_int_pin <= pin_set;
      source_priority_levels <= lvl_set;
   end
endmodule

// >>> bench/testbench.sv
/* Top bench: register bus master, source model and checks.
   Assumes the register map and timing of the block's hand-over. */
`timescale 1ns/1ps
module testbench
   import iec_pkg::*;
;
   logic        mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, spi_req, second_pci_controller_req, audio_codec_link_req;
   logic        audio_codec_power_event_req, pci_power_management_req, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr_seen;
   logic [3:0]  s_axi_wstrb, second_dma_unit_req, strb;
   logic [5:0]  ext_int_pin, pin_set;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [22:0] other_req;
   logic [31:0] s_axi_wdata, s_axi_rdata, source_request_vector, req_set;
   logic [95:0] source_priority_levels, lvl_set;
   int          err_total, checks_done, stall;

   iec_edge_clear_pending iec_edge_clear_pending_inst (.mclk, .sys_rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spi_req,
      .second_dma_unit_req, .second_pci_controller_req, .audio_codec_power_event_req,
      .audio_codec_link_req, .pci_power_management_req, .other_req, .ext_int_pin,
      .source_priority_levels, .source_request_vector, .irq);
   iec_src_model iec_src_model_inst (.mclk, .req_set, .pin_set, .lvl_set, .spi_req,
      .second_dma_unit_req, .second_pci_controller_req, .audio_codec_power_event_req,
      .audio_codec_link_req, .pci_power_management_req, .other_req, .ext_int_pin,
      .source_priority_levels);

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // A wait that ran out ends the run
   task automatic guard(input int n);
      if (n == 40) begin
         err_total++;
         end_sim();
      end
   endtask

   // Ready is held back stall cycles to exercise slave hold
   task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] r);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         s_axi_bready <= (n >= stall);
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      guard(n);
      @(posedge mclk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         s_axi_rready <= (n >= stall);
      end
      v = s_axi_rdata;
      rr_seen = s_axi_rresp;
      s_axi_rready <= 1'b0;
      guard(n);
      @(posedge mclk);
   endtask

   initial begin
      logic [31:0] d, m;
      logic [31:0] noop [6];
      logic [3:0]  codes [6];
      logic [1:0]  r;
      int          k;
      noop  = '{32'h107, 32'h108, 32'h10C, 32'h100, 32'h101, 32'h002};
      codes = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hB};
      sys_rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_set, pin_set, lvl_set} = '0;
      s_axi_wstrb = 4'hF;
      strb = 4'hF;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(OFS_CLEAR_CMD, d);
      chk("cmd reset", d, 32'h0);
      rd(OFS_PENDING, d);
      chk("pend reset", d, 32'h0);
      chk("pend rresp", rr_seen, RESP_OKAY);
      $display("reset test done");
      // All on-chip sources, level of source 31 left at zero
      req_set <= 32'hFFFF_FFFF;
      lvl_set <= {3'h0, {31{3'h1}}};
      repeat (4) @(posedge mclk);
      rd(OFS_PENDING, d);
      chk("pend all", d, 32'hFFEF_FF03);
      chk("delivered", source_request_vector, 32'h7FEF_FF03);
      stall = 2;
      for (k = 23; k < 32; k++) begin
         req_set <= 32'h1 << k;
         repeat (4) @(posedge mclk);
         rd(OFS_PENDING, d);
         chk("pend bit", d, 32'h1 << k);
      end
      wr(OFS_PENDING, 32'h0, r);
      chk("pend wr resp", r, RESP_OKAY);
      rd(OFS_PENDING, d);
      chk("pend kept", d, 32'h8000_0000);
      wr(16'hF700, 32'h0, r);
      chk("unmapped", r, RESP_SLVERR);
      rd(16'hF700, d);
      chk("unmapped rd", d, 32'h0);
      chk("unmapped rresp", rr_seen, RESP_SLVERR);
      wr(OFS_CLEAR_CMD, 32'hFFFF_FFFC, r);
      rd(OFS_CLEAR_CMD, d);
      chk("cmd readback", d, 32'hC);
      stall = 0;
      $display("register test done");
      // Latch all six pins, then commands that clear nothing
      req_set <= 32'h0;
      pin_set <= 6'h3F;
      repeat (8) @(posedge mclk);
      m = 32'hFC;
      for (k = 0; k < 7; k++) begin
         strb = (k == 6) ? 4'h1 : 4'hF;
         wr(OFS_CLEAR_CMD, (k == 6) ? 32'h102 : noop[k], r);
         rd(OFS_PENDING, d);
         chk("no clear", d, m);
      end
      strb = 4'hF;
      rd(OFS_IRQ_STATUS, d);
      chk("status", d, 32'h3F);
      chk("irq masked", irq, 32'h0);
      for (k = 0; k < 6; k++) begin
         wr(OFS_CLEAR_CMD, 32'h100 | codes[k], r);
         repeat (2) @(posedge mclk);
         m[k+2] = 1'b0;
         rd(OFS_PENDING, d);
         chk("clear", d, m);
      end
      $display("edge clear test done");
      wr(OFS_IRQ_MASK, 32'h1, r);
      repeat (2) @(posedge mclk);
      chk("irq on", irq, 32'h1);
      wr(OFS_IRQ_STATUS, 32'h1, r);
      repeat (2) @(posedge mclk);
      chk("irq off", irq, 32'h0);
      rd(OFS_IRQ_STATUS, d);
      chk("status w1c", d, 32'h3E);
      $display("interrupt test done");
      end_sim();
   end
endmodule
